// >>> dmaabu_top.sv
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module dmaabu_top import dmaabu_pkg::*; (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic step_i,
  input wire logic [1:0] check_space_i,
  input wire logic [ADDR_W-1:0] check_addr_i,
  output logic check_allowed_o,
  output logic [ADDR_W-1:0] address_o,
  output logic [PAGE_W+ADDR_W-1:0] src_program_addr_o,
  output logic [PAGE_W+ADDR_W-1:0] dst_program_addr_o,
  output logic half_irq_o,
  output logic full_irq_o
);

  // ****************************************
  // apb slave
  // ****************************************

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_SRC_PAGE) || (a == OFF_DST_PAGE) ||
             (a == OFF_CONFIG) || (a == OFF_BASE) || (a == OFF_SIZE) ||
             (a == OFF_CURRENT) || (a == OFF_INDEX) ||
             (a == OFF_STEP) || (a == OFF_STATUS);
  endfunction : mapped

  // byte-lane merge of a 16-bit register
  function automatic logic [ADDR_W-1:0] merge16(
      input logic [ADDR_W-1:0] old, input logic [31:0] wd,
      input logic [3:0] strb);
    merge16 = {strb[1] ? wd[15:8] : old[15:8],
               strb[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [PAGE_W-1:0] src_page_reg, src_page_next;
  logic [PAGE_W-1:0] dst_page_reg, dst_page_next;
  logic [CFG_W-1:0] config_reg, config_next;
  logic [ADDR_W-1:0] base_reg, base_next;
  logic [ADDR_W-1:0] size_reg, size_next;
  logic [ADDR_W-1:0] index_reg, index_next;
  logic [ADDR_W-1:0] current_reg, current_next;
  logic half_reg, half_next;
  logic full_reg, full_next;
  logic allowed_reg, allowed_next;
  logic apb_commit, apb_wr, sw_step, step_fire;
  logic cur_write;
  dmaabu_region_type check_region;

  // one wait state: pready is a flop so that read data is too
  assign apb_commit = psel_i && penable_i && pready_reg;
  assign apb_wr = apb_commit && pwrite_i && mapped(paddr_i);
  assign sw_step = apb_wr && (paddr_i == OFF_STEP);
  assign cur_write = apb_wr && (paddr_i == OFF_CURRENT);
  // a software write of the address beats a step in the same cycle
  assign step_fire = (step_i || sw_step) && !cur_write;

  // read mux, answer and error flag for the access phase
  always_comb begin
    pready_next = psel_i && penable_i && !pready_reg;
    pslverr_next = psel_i && penable_i && !pready_reg && !mapped(paddr_i);
    prdata_next = 32'h0000_0000;
    if (psel_i && penable_i && !pready_reg && !pwrite_i) begin
      unique case (paddr_i)
        OFF_SRC_PAGE: prdata_next = {25'h0, src_page_reg};
        OFF_DST_PAGE: prdata_next = {25'h0, dst_page_reg};
        OFF_CONFIG: prdata_next = {29'h0, config_reg};
        OFF_BASE: prdata_next = {16'h0, base_reg};
        OFF_SIZE: prdata_next = {16'h0, size_reg};
        OFF_CURRENT: prdata_next = {16'h0, current_reg};
        OFF_INDEX: prdata_next = {16'h0, index_reg};
        OFF_STATUS: prdata_next = {30'h0, full_reg, half_reg};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // software-written registers
  always_comb begin
    src_page_next = src_page_reg;
    dst_page_next = dst_page_reg;
    config_next = config_reg;
    base_next = base_reg;
    size_next = size_reg;
    index_next = index_reg;
    if (apb_wr) begin
      unique case (paddr_i)
        OFF_SRC_PAGE: if (pstrb_i[0]) begin
          src_page_next = pwdata_i[PAGE_W-1:0];
        end
        OFF_DST_PAGE: if (pstrb_i[0]) begin
          dst_page_next = pwdata_i[PAGE_W-1:0];
        end
        OFF_CONFIG: if (pstrb_i[0]) begin
          config_next = pwdata_i[CFG_W-1:0];
        end
        OFF_BASE: base_next = merge16(base_reg, pwdata_i, pstrb_i);
        OFF_SIZE: size_next = merge16(size_reg, pwdata_i, pstrb_i);
        OFF_INDEX: index_next = merge16(index_reg, pwdata_i, pstrb_i);
        default: ;
      endcase
    end
  end

  // pages reset to zero and only software changes them
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      src_page_reg <= PAGE_RESET;
      dst_page_reg <= PAGE_RESET;
      config_reg <= CFG_RESET;
      base_reg <= ADDR_RESET;
      size_reg <= ADDR_RESET;
      index_reg <= ADDR_RESET;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      src_page_reg <= src_page_next;
      dst_page_reg <= dst_page_next;
      config_reg <= config_next;
      base_reg <= base_next;
      size_reg <= size_next;
      index_reg <= index_next;
    end
  end

  // ****************************************
  // auto-buffer address stepping
  // ****************************************

  logic signed [ADDR_W+1:0] cand;
  logic signed [ADDR_W+1:0] lim_s, base_s, half_s, cur_s;
  logic [ADDR_W-1:0] limit, halfway;
  logic neg_index, wrap, cross_half, auto_buffering_mode, irq_en;

  assign auto_buffering_mode = config_reg[CFG_TRANSFER_MODE];
  assign irq_en = config_reg[CFG_IRQ_ENABLE];
  assign neg_index = index_reg[ADDR_W-1];
  assign limit = ADDR_W'(base_reg + size_reg - 16'h0001);
  assign halfway = ADDR_W'(base_reg + (size_reg >> 1));
  assign cur_s = $signed({2'b00, current_reg});
  assign base_s = $signed({2'b00, base_reg});
  assign lim_s = $signed({2'b00, limit});
  assign half_s = $signed({2'b00, halfway});
  assign cand = cur_s + $signed({{2{index_reg[ADDR_W-1]}}, index_reg});

  // wrap and half detection from the computed next address
  always_comb begin
    wrap = neg_index ? (cand < base_s) : (cand > lim_s);
    if (neg_index) begin
      cross_half = (cur_s >= half_s) && (cand < half_s);
    end else begin
      cross_half = (cur_s <= half_s) && (cand > half_s);
    end
    cross_half = cross_half && !wrap;
  end

  // next address and events; the page never takes a carry
  always_comb begin
    current_next = current_reg;
    half_next = 1'b0;
    full_next = 1'b0;
    if (cur_write) begin
      current_next = merge16(current_reg, pwdata_i, pstrb_i);
    end else if (step_fire && size_reg != ADDR_RESET) begin
      if (wrap) begin
        current_next = neg_index ? limit : base_reg;
      end else begin
        current_next = cand[ADDR_W-1:0]; // 64K wrap in page
      end
      // only auto-buffer mode with enable set raises events
      full_next = wrap && auto_buffering_mode && irq_en;
      half_next = cross_half && auto_buffering_mode && irq_en &&
                  config_reg[CFG_IRQ_MODE];
    end
  end

  // address and event pulses, registered
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      current_reg <= ADDR_RESET;
      half_reg <= 1'b0;
      full_reg <= 1'b0;
    end else begin
      current_reg <= current_next;
      half_reg <= half_next;
      full_reg <= full_next;
    end
  end

  // ****************************************
  // reach check and program addresses
  // ****************************************

  dmaabu_map_decode u_map (
    .space_i(check_space_i),
    .addr_i(check_addr_i),
    .region_o(check_region)
  );

  always_comb begin
    allowed_next = (check_region != REGION_RESERVED);
  end

  // reach answer one cycle after the query
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      allowed_reg <= 1'b0;
    end else begin
      allowed_reg <= allowed_next;
    end
  end

  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign prdata_o = prdata_reg;
  assign check_allowed_o = allowed_reg;
  assign address_o = current_reg;
  assign half_irq_o = half_reg;
  assign full_irq_o = full_reg;
  // shared pages ahead of the stepped address, every channel
  assign src_program_addr_o = {src_page_reg, current_reg};
  assign dst_program_addr_o = {dst_page_reg, current_reg};

  // ****************************************
  // checks
  // ****************************************

  logic step_ok;
  assign step_ok = step_fire && size_reg != ADDR_RESET;

  // every check runs on the block clock and sleeps through reset
  default clocking chk_clk @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  chk_no_irq_off: assert property (
    (step_ok && !irq_en) |=> !half_irq_o && !full_irq_o)
    else $error("event raised with interrupts disabled");

  chk_half_mode: assert property (
    half_irq_o |-> $past(config_reg) == 3'h7)
    else $error("half event outside half-and-full auto-buffer mode");

  chk_half_up: assert property (
    (step_ok && config_reg == 3'h7 && index_reg == 16'h0001 &&
     current_reg == halfway && current_reg != limit)
    |=> half_irq_o && address_o == $past(halfway) + 16'h0001)
    else $error("half event missed going up");

  chk_half_down: assert property (
    (step_ok && config_reg == 3'h7 && index_reg == 16'hffff &&
     current_reg == halfway && current_reg != base_reg)
    |=> half_irq_o && !full_irq_o)
    else $error("half event missed going down");

  chk_full_wrap: assert property (
    (step_ok && auto_buffering_mode && irq_en && index_reg == 16'h0001 &&
     current_reg == limit) |=> full_irq_o && address_o == $past(base_reg))
    else $error("up wrap to base not flagged");

  chk_full_down: assert property (
    (step_ok && auto_buffering_mode && irq_en && index_reg == 16'hffff &&
     current_reg == base_reg) |=> full_irq_o && address_o == $past(limit))
    else $error("down wrap to top not flagged");

  chk_page_stable: assert property (
    !(apb_wr && paddr_i == OFF_SRC_PAGE) |=> $stable(src_page_reg))
    else $error("source page changed without a write");

  chk_page_upper: assert property (
    (apb_commit && !pwrite_i && (paddr_i == OFF_SRC_PAGE ||
     paddr_i == OFF_DST_PAGE)) |-> prdata_o[31:PAGE_W] == 25'h0)
    else $error("reserved page bits read nonzero");

  chk_reach_io: assert property (
    (check_space_i != SPACE_DATA) |=> !check_allowed_o)
    else $error("program or io space reported reachable");

  chk_reach_ram: assert property (
    (check_space_i == SPACE_DATA && check_addr_i >= 16'h4000)
    |=> !check_allowed_o)
    else $error("data above 3fff reported reachable");

  chk_reach_port: assert property (
    (check_space_i == SPACE_DATA && check_addr_i[15:2] == 14'h0010)
    |=> check_allowed_o)
    else $error("port one word reported unreachable");

  cov_half: cover property (half_irq_o ##[1:64] full_irq_o);
  cov_read: cover property (
    apb_commit && !pwrite_i && paddr_i == OFF_CURRENT);
  cov_error: cover property (pslverr_o);

endmodule : dmaabu_top

// >>> dmaabu_pkg.sv
// Behaviour
// - auto-buffering mode is picked by a transfer_mode_bit of one.
// - events need channel_interrupt_enable; interrupt_mode_bit adds half.
// - going up, half fires when the next address first exceeds halfway.
// - going down, half fires as the next address drops below halfway.
// - full fires on a wrap, to the base going up, to the top going down.
// - source and destination page registers hold a 7-bit page in bits 6:0.
// - reset clears both program page registers to page zero.
// - the reserved upper bits of both page registers always read as zero.
// - one shared pair of page registers serves every channel's accesses.
// - stepping never touches the page, so a 64K crossing stays in page.
// - the whole program space and I/O space are closed to the DMA.
// - port zero's receive and transmit words sit at data 0020 to 0023.
// - port one's receive and transmit words sit at data 0040 to 0043.
// - scratchpad 0060-007f and dual RAM 0080-3fff; other data reserved.
// - the map decode ignores the processor's three memory mode bits.
package dmaabu_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_SRC_PAGE = 8'h00;
  localparam logic [7:0] OFF_DST_PAGE = 8'h04;
  localparam logic [7:0] OFF_CONFIG = 8'h08;
  localparam logic [7:0] OFF_BASE = 8'h0c;
  localparam logic [7:0] OFF_SIZE = 8'h10;
  localparam logic [7:0] OFF_CURRENT = 8'h14;
  localparam logic [7:0] OFF_INDEX = 8'h18;
  localparam logic [7:0] OFF_STEP = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam int PAGE_W = 7;
  localparam int ADDR_W = 16;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
  localparam int CFG_TRANSFER_MODE = 0;
  localparam int CFG_IRQ_ENABLE = 1;
  localparam int CFG_IRQ_MODE = 2;
  localparam int CFG_W = 3;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;
  localparam int STAT_HALF = 0;
  localparam int STAT_FULL = 1;

  // ****************************************
  // address spaces and data-space map
  // ****************************************
  localparam logic [1:0] SPACE_PROGRAM = 2'h0;
  localparam logic [1:0] SPACE_DATA = 2'h1;
  localparam logic [1:0] SPACE_IO = 2'h2;
  localparam logic [ADDR_W-1:0] PORT0_LO = 16'h0020;
  localparam logic [ADDR_W-1:0] PORT0_HI = 16'h0023;
  localparam logic [ADDR_W-1:0] PORT1_LO = 16'h0040;
  localparam logic [ADDR_W-1:0] PORT1_HI = 16'h0043;
  localparam logic [ADDR_W-1:0] SCRATCH_LO = 16'h0060;
  localparam logic [ADDR_W-1:0] SCRATCH_HI = 16'h007f;
  localparam logic [ADDR_W-1:0] DUAL_RAM_LO = 16'h0080;
  localparam logic [ADDR_W-1:0] DUAL_RAM_HI = 16'h3fff;

  typedef enum logic [2:0] {
    REGION_RESERVED,
    REGION_PORT0,
    REGION_PORT1,
    REGION_SCRATCH,
    REGION_DUAL_RAM
  } dmaabu_region_type;

endpackage : dmaabu_pkg

// >>> dmaabu_map_decode.sv
`timescale 1ns/1ps
module dmaabu_map_decode import dmaabu_pkg::*; (
  input wire logic [1:0] space_i,
  input wire logic [ADDR_W-1:0] addr_i,
  output dmaabu_region_type region_o
);

  // ****************************************
  // dma reach decode
  // ****************************************

  function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // no processor mode bit enters here: the map is fixed
  always_comb begin
    region_o = REGION_RESERVED; // program and io spaces
    if (space_i == SPACE_DATA) begin
      if (in_range(addr_i, PORT0_LO, PORT0_HI)) begin
        region_o = REGION_PORT0;
      end else if (in_range(addr_i, PORT1_LO, PORT1_HI)) begin
        region_o = REGION_PORT1;
      end else if (in_range(addr_i, SCRATCH_LO, SCRATCH_HI)) begin
        region_o = REGION_SCRATCH;
      end else if (in_range(addr_i, DUAL_RAM_LO, DUAL_RAM_HI)) begin
        region_o = REGION_DUAL_RAM;
      end
    end
  end

endmodule : dmaabu_map_decode

// >>> dmaabu_seq_model.sv
`timescale 1ns/1ps
// ****************************************
// sequencer stand-in: issues step pulses
// ****************************************
module dmaabu_seq_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [7:0] count_i,
  input wire logic [1:0] gap_i,
  output logic step_o,
  output logic busy_o
);
  logic [7:0] left_reg, left_next;
  logic [1:0] wait_reg, wait_next;
  logic [1:0] gap_reg, gap_next;
  logic step_next;

  // a new burst is ignored while one is running, as a real sequencer would
  always_comb begin
    left_next = left_reg;
    wait_next = wait_reg;
    gap_next = gap_reg;
    step_next = 1'b0;
    if (start_i && left_reg == 8'h00) begin
      left_next = count_i;
      wait_next = 2'h0;
      gap_next = gap_i;
    end else if (left_reg != 8'h00) begin
      if (wait_reg == 2'h0) begin
        step_next = 1'b1;
        left_next = left_reg - 8'h01;
        wait_next = gap_reg; // gap 0 gives back-to-back steps
      end else begin
        wait_next = wait_reg - 2'h1;
      end
    end
  end

  // state registers only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      left_reg <= 8'h00;
      wait_reg <= 2'h0;
      gap_reg <= 2'h0;
      step_o <= 1'b0;
    end else begin
      left_reg <= left_next;
      wait_reg <= wait_next;
      gap_reg <= gap_next;
      step_o <= step_next;
    end
  end

  assign busy_o = (left_reg != 8'h00);
endmodule : dmaabu_seq_model

// >>> dma_abu_irq_and_page_addressing_tb.sv
`timescale 1ns/1ps
module dma_abu_irq_and_page_addressing_tb import dmaabu_pkg::*; ;
  logic clk = 1'b0, resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata_o;
  logic pready_o, pslverr_o, step, busy, start = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic [1:0] gap = 2'h0, csp = 2'h0;
  logic [15:0] caddr = 16'h0, address_o, b, s, ix, exp_cur, cc;
  logic [22:0] src_o, dst_o;
  logic [6:0] sp, dp;
  logic [2:0] cfg;
  logic allowed_o, half_o, full_o, mon_on = 1'b0, eh, ef;
  logic [17:0] p;
  logic [31:0] ra;
  int miscompares = 0, samples_checked = 0;
  logic [15:0] corners [15] = '{16'h001f, 16'h0020, 16'h0023, 16'h0024,
    16'h003f, 16'h0040, 16'h0043, 16'h0044, 16'h005f, 16'h0060, 16'h007f,
    16'h0080, 16'h3fff, 16'h4000, 16'hffff};

  always #20 clk = ~clk;

  dmaabu_top dut (.clock_i(clk), .resetn_i(resetn), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .step_i(step),
    .check_space_i(csp), .check_addr_i(caddr),
    .check_allowed_o(allowed_o), .address_o(address_o),
    .src_program_addr_o(src_o), .dst_program_addr_o(dst_o),
    .half_irq_o(half_o), .full_irq_o(full_o));

  dmaabu_seq_model seq (.clk_i(clk), .resetn_i(resetn), .start_i(start),
    .count_i(cnt), .gap_i(gap), .step_o(step), .busy_o(busy));

  // ****************************************
  // reporting
  // ****************************************
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask : chk

  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  // ****************************************
  // apb master, one idle cycle between transfers
  // ****************************************
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdchk(string name, logic [7:0] a, logic [31:0] exp,
                       logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(name, rd, exp);
    chk({name, " error"}, 32'(err), 32'(exp_err));
  endtask : rdchk

  // ****************************************
  // expectations
  // ****************************************
  // worked in int so a step below address zero still counts as a wrap
  function automatic logic [17:0] predict(logic [15:0] cur);
    int n, top, hw;
    logic w, h, en;
    n = int'(cur) + int'($signed(ix));
    top = int'(b) + int'(s) - 1;
    hw = int'(b) + int'(s) / 2;
    w = 1'b0;
    if (n > top) begin
      n = int'(b);
      w = 1'b1;
    end else if (n < int'(b)) begin
      n = top;
      w = 1'b1;
    end
    h = !w && ((int'(cur) <= hw && n > hw) || (int'(cur) >= hw && n < hw));
    en = cfg[0] & cfg[1];
    return {en & w, en & cfg[2] & h, 16'(n)};
  endfunction : predict

  function automatic logic reach(logic [1:0] sp_a, logic [15:0] a);
    if (sp_a != 2'h1) return 1'b0;
    return (a >= 16'h0020 && a <= 16'h0023) ||
      (a >= 16'h0040 && a <= 16'h0043) || (a >= 16'h0060 && a <= 16'h3fff);
  endfunction : reach

  // ****************************************
  // step monitor
  // ****************************************
  always @(posedge clk) begin
    if (mon_on) begin
      if (step === 1'b1) begin
        p = predict(exp_cur);
        exp_cur = p[15:0];
        eh = p[16];
        ef = p[17];
      end else begin
        eh = 1'b0;
        ef = 1'b0;
      end
      #1;
      chk("address", 32'(address_o), 32'(exp_cur));
      chk("half", 32'(half_o), 32'(eh));
      chk("full", 32'(full_o), 32'(ef));
      chk("src prog", 32'(src_o), 32'({sp, exp_cur}));
      chk("dst prog", 32'(dst_o), 32'({dp, exp_cur}));
    end
  end

  task automatic run(logic [2:0] c, logic [15:0] bb, logic [15:0] ss,
                     logic [15:0] ii, logic [15:0] c0, int steps);
    int n;
    cfg = c;
    b = bb;
    s = ss;
    ix = ii;
    wr(OFF_CONFIG, 32'(c));
    wr(OFF_BASE, 32'(bb));
    wr(OFF_SIZE, 32'(ss));
    wr(OFF_INDEX, 32'(ii));
    wr(OFF_CURRENT, 32'(c0));
    exp_cur = c0;
    mon_on = 1'b1;
    start <= 1'b1;
    cnt <= 8'(steps);
    gap <= 2'($urandom % 3);
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy === 1'b1 && n < 400);
    if (n >= 400) begin
      miscompares++;
      finish_test();
    end
    repeat (2) @(posedge clk);
    mon_on = 1'b0;
  endtask : run

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hbf7a));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdchk("src page reset", OFF_SRC_PAGE, 32'h0, 1'b0);
    rdchk("dst page reset", OFF_DST_PAGE, 32'h0, 1'b0);
    wr(OFF_SRC_PAGE, 32'hffffffff);
    wr(OFF_DST_PAGE, 32'hffffff80);
    rdchk("src page", OFF_SRC_PAGE, 32'h7f, 1'b0);
    rdchk("dst page", OFF_DST_PAGE, 32'h0, 1'b0);
    rdchk("unmapped", 8'h24, 32'h0, 1'b1);
    sp = 7'($urandom);
    dp = 7'($urandom);
    wr(OFF_SRC_PAGE, {25'($urandom), sp});
    wr(OFF_DST_PAGE, {25'($urandom), dp});
    rdchk("src page rand", OFF_SRC_PAGE, 32'(sp), 1'b0);
    // documented odd and even buffers both ways, then a top-of-page buffer
    run(3'h7, 16'h0000, 16'h0008, 16'h0001, 16'h0000, 17);
    run(3'h7, 16'h0000, 16'h0007, 16'h0001, 16'h0000, 15);
    run(3'h7, 16'h0000, 16'h0008, 16'hffff, 16'h0007, 17);
    run(3'h7, 16'h0000, 16'h0007, 16'hffff, 16'h0006, 15);
    run(3'h7, 16'hfff8, 16'h0008, 16'h0003, 16'hfffc, 12);
    // every mode combination over random buffers
    for (int i = 0; i < 16; i++) begin
      b = 16'h0100 + 16'($urandom % 256);
      s = 16'(4 + $urandom % 13);
      ix = 16'(1 + $urandom % 3);
      if ($urandom % 2) ix = -ix;
      cc = b + 16'($urandom % s);
      run(3'(i), b, s, ix, cc, 2 * int'(s) + 3);
    end
    // software step register: a step off the top lands on the base
    wr(OFF_BASE, 32'h0);
    wr(OFF_SIZE, 32'h8);
    wr(OFF_INDEX, 32'h1);
    wr(OFF_CURRENT, 32'h7);
    wr(OFF_STEP, 32'h0);
    rdchk("sw step", OFF_CURRENT, 32'h0, 1'b0);
    rdchk("src page kept", OFF_SRC_PAGE, 32'(sp), 1'b0);
    // map decode: corners in every space, then random addresses
    for (int i = 0; i < 100; i++) begin
      csp <= (i < 60) ? 2'(i / 15) : 2'($urandom);
      caddr <= (i < 60) ? corners[i % 15] : 16'($urandom);
      @(posedge clk);
      #1;
      ra = 32'(reach(csp, caddr));
      chk("reach", 32'(allowed_o), ra);
      @(posedge clk);
    end
    finish_test();
  end
endmodule : dma_abu_irq_and_page_addressing_tb
